// ---- hdl/aawc_defines.svh ----
`ifndef AAWC_DEFINES_SVH
`define AAWC_DEFINES_SVH

// ============================================================
// Register offsets (byte addresses on the register port)
// ============================================================
`define AAWC_OFS_WIN_SEL 8'h00
`define AAWC_OFS_WIN_XOFF 8'h04
`define AAWC_OFS_WIN_YOFF 8'h08
`define AAWC_OFS_WIN_W 8'h0C
`define AAWC_OFS_WIN_H 8'h10
`define AAWC_OFS_MODE0 8'h14
`define AAWC_OFS_MODE1 8'h18
`define AAWC_OFS_TARGET0 8'h1C
`define AAWC_OFS_LOWER0 8'h20
`define AAWC_OFS_UPPER0 8'h24
`define AAWC_OFS_PARAM0 8'h28
`define AAWC_OFS_PARAM1 8'h2C
`define AAWC_OFS_STATUS 8'h30

// ============================================================
// Field positions and reset values
// ============================================================
`define AAWC_MODE_LSB 0
`define AAWC_ST_HIT0 0
`define AAWC_ST_HIT1 1
`define AAWC_ST_REACHED0 2
`define AAWC_ST_REACHED1 3
`define AAWC_ST_LIMIT0 4
`define AAWC_ST_LIMIT1 5
`define AAWC_RST_TARGET 8'h80
`define AAWC_RST_LOWER 16'h0000
`define AAWC_RST_UPPER 16'hFFFF
`define AAWC_RST_PARAM 16'h0000

// ============================================================
// Frame counts
// ============================================================
`define AAWC_ONCE_MAX_FRAMES 5'd30

`endif

// ---- hdl/aawc_pkg.sv ----
package aawc_pkg;

  typedef enum logic [1:0] {
    AAWC_OFF,
    AAWC_ONCE,
    AAWC_CONT
  } aawc_mode_t;

  // Intersection of one statistics window with the crop, plus its sums.
  typedef struct packed {
    logic [15:0] x0;
    logic [15:0] x1;
    logic [15:0] y0;
    logic [15:0] y1;
    logic hit;
    logic [39:0] sum;
    logic [31:0] cnt;
  } aawc_win_t;

  typedef struct packed {
    aawc_mode_t mode;
    logic [15:0] param;
    logic [4:0] tries;
    logic phase;
    logic armed;
    logic reached;
    logic at_limit;
  } aawc_fn_t;

  typedef struct packed {
    logic sel;
    logic [1:0][15:0] wx;
    logic [1:0][15:0] wy;
    logic [1:0][15:0] ww;
    logic [1:0][15:0] wh;
    logic [7:0] target;
    logic [15:0] lo;
    logic [15:0] hi;
    aawc_win_t [1:0] win;
    aawc_fn_t [1:0] fn;
    logic [31:0] rdata;
  } aawc_state_t;

endpackage

// ---- hdl/aawc_top.sv ----
`timescale 1ns/1ps
`include "aawc_defines.svh"
// Summary of operation
// - Auto adjustment overwrites the manual parameter; nothing is restored.
// - Function 0 uses a set target and limits; function 1 a fixed target.
// - Once mode adjusts to the target, then turns off; the value stays.
// - Continuous mode adjusts each frame, or every second one at high rate.
// - Continuous runs until once or off chosen; last value stays in effect.
// - Off mode holds the last derived value until software writes a new one.
// - Modes and settings may change while frames are being captured.
// - A newly enabled function starts with the next full frame.
// - Once mode gives up after at most 30 frames and returns to off.
// - Unreachable targets are approached as far as the limits allow.
// - Window coordinates count from column 0, row 0 at the top left.
// - Only pixels inside start, width and height of a window are used.
// - Only pixels in window and crop overlap feed the whole-frame control.
// - Without overlap a function makes no adjustment at all.
// - Each function has its window by map; windows may be shared.
// - After reset every window covers the full sensor.
// - Window offsets and sizes are set in steps of one pixel.
// - With binning, coordinates and data are the binned ones.
// - Brightness is the average grey level on an 8-bit scale.
module aawc_top
  import aawc_pkg::*;
#(
  parameter int SENSOR_W = 659,
  parameter int SENSOR_H = 494,
  parameter int PIX_W = 12,
  parameter logic [15:0] STEP = 16'h0010,
  parameter logic [7:0] FIXED_TARGET1 = 8'h80,
  parameter bit WIN_OF_FN1 = 1'b1
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic frame_start_i,
  input wire logic frame_end_i,
  input wire logic frame_rate_high_i,
  input wire logic pix_valid_i,
  input wire logic [15:0] pix_col_i,
  input wire logic [15:0] pix_row_i,
  input wire logic [PIX_W-1:0] pix_data_i,
  input wire logic [15:0] crop_x_i,
  input wire logic [15:0] crop_y_i,
  input wire logic [15:0] crop_w_i,
  input wire logic [15:0] crop_h_i,
  output logic [15:0] param0_o,
  output logic [15:0] param1_o,
  output logic [1:0] auto_active_o
);

  // ============================================================
  // State
  // ============================================================
  localparam logic [15:0] FULL_W = 16'(SENSOR_W);
  localparam logic [15:0] FULL_H = 16'(SENSOR_H);

  aawc_state_t state_reg;
  aawc_state_t state_next;

  // ============================================================
  // Design notes
  // ============================================================
  // The control step runs once per frame end, so the wide product that
  // stands in for the division sits on a slow path; it is still the first
  // timing hazard to look at if the clock is raised.
  // Software writes are applied after the hardware update, so a write in
  // the same cycle as an adjustment or a once-mode stop always wins.
  // Window and crop ends are summed in 17 bits but compared in 16, so the
  // overlap is only right while offset plus size stays below 65536.
  // A function left in once mode with no overlap still counts its frames,
  // so it is sure to drop back to off after the frame limit.

  // Pixel value rescaled to the 8-bit grey scale.
  logic [7:0] pix8;
  assign pix8 = pix_data_i[PIX_W-1 -: 8];

  function automatic logic [15:0] max16(input logic [15:0] a,
                                        input logic [15:0] b);
    max16 = (a > b) ? a : b;
  endfunction

  function automatic logic [15:0] min16(input logic [15:0] a,
                                        input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction

  // ============================================================
  // Next-state logic
  // ============================================================
  always_comb begin
    logic [16:0] wend;
    logic [16:0] cend;
    logic [15:0] e0;
    logic [15:0] e1;
    logic [7:0] tgt;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [40:0] tlo;
    logic [40:0] thi;
    logic low;
    logic high;
    logic [16:0] sum17;
    logic [16:0] np;
    logic clamped;
    logic [4:0] tries;
    int w;

    wend = '0;
    cend = '0;
    e0 = '0;
    e1 = '0;
    tgt = '0;
    lo = '0;
    hi = '0;
    tlo = '0;
    thi = '0;
    low = 1'b0;
    high = 1'b0;
    sum17 = '0;
    np = '0;
    clamped = 1'b0;
    tries = '0;
    w = 0;
    state_next = state_reg;
    state_next.rdata = '0;

    // ============================================================
    // Window overlap and statistics
    // ============================================================
    // Overlap is latched at frame start, then pixels are accumulated.
    for (int i = 0; i < 2; i++) begin
      if (frame_start_i) begin
        // Settings changed mid-frame only take hold here.
        wend = {1'b0, state_reg.wx[i]} + {1'b0, state_reg.ww[i]};
        cend = {1'b0, crop_x_i} + {1'b0, crop_w_i};
        e0 = max16(state_reg.wx[i], crop_x_i);
        e1 = min16(wend[15:0], cend[15:0]);
        state_next.win[i].x0 = e0;
        state_next.win[i].x1 = e1;
        state_next.win[i].hit = (e0 < e1);
        wend = {1'b0, state_reg.wy[i]} + {1'b0, state_reg.wh[i]};
        cend = {1'b0, crop_y_i} + {1'b0, crop_h_i};
        e0 = max16(state_reg.wy[i], crop_y_i);
        e1 = min16(wend[15:0], cend[15:0]);
        state_next.win[i].y0 = e0;
        state_next.win[i].y1 = e1;
        if (!(e0 < e1)) begin
          state_next.win[i].hit = 1'b0;
        end
        state_next.win[i].sum = '0;
        state_next.win[i].cnt = '0;
      end else if (pix_valid_i && state_reg.win[i].hit &&
                   pix_col_i >= state_reg.win[i].x0 &&
                   pix_col_i < state_reg.win[i].x1 &&
                   pix_row_i >= state_reg.win[i].y0 &&
                   pix_row_i < state_reg.win[i].y1) begin
        // Coordinates arrive from column 0, row 0, binned if binning is on.
        state_next.win[i].sum = state_reg.win[i].sum +
                                40'(pix8);
        state_next.win[i].cnt = state_reg.win[i].cnt + 32'h1;
      end
    end

    // ============================================================
    // Function control
    // ============================================================
    // Evaluated once per frame end.
    for (int f = 0; f < 2; f++) begin
      w = (f == 0) ? 0 : int'(WIN_OF_FN1);
      tgt = (f == 0) ? state_reg.target : FIXED_TARGET1;
      lo = (f == 0) ? state_reg.lo : `AAWC_RST_LOWER;
      hi = (f == 0) ? state_reg.hi : `AAWC_RST_UPPER;
      if (frame_start_i) begin
        // Only a frame seen whole from its start is measured.
        state_next.fn[f].armed = (state_reg.fn[f].mode != AAWC_OFF);
      end else if (frame_end_i && state_reg.fn[f].armed &&
                   state_reg.fn[f].mode != AAWC_OFF) begin
        state_next.fn[f].armed = 1'b0;
        state_next.fn[f].phase = ~state_reg.fn[f].phase;
        if (state_reg.fn[f].mode == AAWC_CONT && frame_rate_high_i &&
            state_reg.fn[f].phase) begin
          state_next.fn[f].phase = 1'b0;
        end else begin
          if (state_reg.win[w].hit && state_reg.win[w].cnt != '0) begin
            // Compare sum with target*count instead of dividing.
            tlo = 41'(state_reg.win[w].cnt) * 41'(tgt);
            thi = tlo + 41'(state_reg.win[w].cnt);
            low = {1'b0, state_reg.win[w].sum} < tlo;
            high = {1'b0, state_reg.win[w].sum} >= thi;
            np = {1'b0, state_reg.fn[f].param};
            clamped = 1'b0;
            if (low) begin
              sum17 = {1'b0, state_reg.fn[f].param} + {1'b0, STEP};
              np = sum17;
              if (sum17 > {1'b0, hi}) begin
                np = {1'b0, hi};
                clamped = 1'b1;
              end
            end else if (high) begin
              np = {1'b0, state_reg.fn[f].param} - {1'b0, STEP};
              if ({1'b0, state_reg.fn[f].param} <
                  {1'b0, lo} + {1'b0, STEP}) begin
                np = {1'b0, lo};
                clamped = 1'b1;
              end
            end
            state_next.fn[f].param = np[15:0];
            state_next.fn[f].reached = !(low || high);
            state_next.fn[f].at_limit = clamped;
          end else begin
            // No overlap: the parameter is left as it stands.
            state_next.fn[f].reached = 1'b0;
            state_next.fn[f].at_limit = 1'b0;
          end
          if (state_reg.fn[f].mode == AAWC_ONCE) begin
            tries = state_reg.fn[f].tries + 5'h1;
            state_next.fn[f].tries = tries;
            if (state_next.fn[f].reached) begin
              state_next.fn[f].mode = AAWC_OFF;
            end else if (tries == `AAWC_ONCE_MAX_FRAMES) begin
              state_next.fn[f].mode = AAWC_OFF;
            end
          end
        end
      end
    end

    // ============================================================
    // Software writes
    // ============================================================
    // Software writes come last so that they win over a same-cycle update.
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `AAWC_OFS_WIN_SEL: begin
          state_next.sel = reg_wdata_i[0];
        end
        `AAWC_OFS_WIN_XOFF: begin
          state_next.wx[state_reg.sel] = reg_wdata_i[15:0];
        end
        `AAWC_OFS_WIN_YOFF: begin
          state_next.wy[state_reg.sel] = reg_wdata_i[15:0];
        end
        `AAWC_OFS_WIN_W: begin
          state_next.ww[state_reg.sel] = reg_wdata_i[15:0];
        end
        `AAWC_OFS_WIN_H: begin
          state_next.wh[state_reg.sel] = reg_wdata_i[15:0];
        end
        `AAWC_OFS_MODE0, `AAWC_OFS_MODE1: begin
          w = (reg_addr_i == `AAWC_OFS_MODE0) ? 0 : 1;
          // Code 3 is not a mode and is taken as off.
          state_next.fn[w].mode = (reg_wdata_i[1:0] == 2'h3) ? AAWC_OFF :
                                  aawc_mode_t'(reg_wdata_i[1:0]);
          state_next.fn[w].tries = '0;
          state_next.fn[w].phase = 1'b0;
          state_next.fn[w].armed = 1'b0;
        end
        `AAWC_OFS_TARGET0: begin
          state_next.target = reg_wdata_i[7:0];
        end
        `AAWC_OFS_LOWER0: begin
          state_next.lo = reg_wdata_i[15:0];
        end
        `AAWC_OFS_UPPER0: begin
          state_next.hi = reg_wdata_i[15:0];
        end
        `AAWC_OFS_PARAM0: begin
          state_next.fn[0].param = reg_wdata_i[15:0];
        end
        `AAWC_OFS_PARAM1: begin
          state_next.fn[1].param = reg_wdata_i[15:0];
        end
        default: ;
      endcase
    end

    // ============================================================
    // Read-back
    // ============================================================
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `AAWC_OFS_WIN_SEL: begin
          state_next.rdata = {31'h0, state_reg.sel};
        end
        `AAWC_OFS_WIN_XOFF: begin
          state_next.rdata = {16'h0, state_reg.wx[state_reg.sel]};
        end
        `AAWC_OFS_WIN_YOFF: begin
          state_next.rdata = {16'h0, state_reg.wy[state_reg.sel]};
        end
        `AAWC_OFS_WIN_W: begin
          state_next.rdata = {16'h0, state_reg.ww[state_reg.sel]};
        end
        `AAWC_OFS_WIN_H: begin
          state_next.rdata = {16'h0, state_reg.wh[state_reg.sel]};
        end
        `AAWC_OFS_MODE0: begin
          state_next.rdata = {30'h0, state_reg.fn[0].mode};
        end
        `AAWC_OFS_MODE1: begin
          state_next.rdata = {30'h0, state_reg.fn[1].mode};
        end
        `AAWC_OFS_TARGET0: begin
          state_next.rdata = {24'h0, state_reg.target};
        end
        `AAWC_OFS_LOWER0: begin
          state_next.rdata = {16'h0, state_reg.lo};
        end
        `AAWC_OFS_UPPER0: begin
          state_next.rdata = {16'h0, state_reg.hi};
        end
        `AAWC_OFS_PARAM0: begin
          state_next.rdata = {16'h0, state_reg.fn[0].param};
        end
        `AAWC_OFS_PARAM1: begin
          state_next.rdata = {16'h0, state_reg.fn[1].param};
        end
        `AAWC_OFS_STATUS: begin
          state_next.rdata[`AAWC_ST_HIT0] = state_reg.win[0].hit;
          state_next.rdata[`AAWC_ST_HIT1] = state_reg.win[1].hit;
          state_next.rdata[`AAWC_ST_REACHED0] = state_reg.fn[0].reached;
          state_next.rdata[`AAWC_ST_REACHED1] = state_reg.fn[1].reached;
          state_next.rdata[`AAWC_ST_LIMIT0] = state_reg.fn[0].at_limit;
          state_next.rdata[`AAWC_ST_LIMIT1] = state_reg.fn[1].at_limit;
        end
        default: state_next.rdata = '0;
      endcase
    end
  end

  // ============================================================
  // Registers
  // ============================================================
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
      state_reg.wx <= '0;
      state_reg.wy <= '0;
      state_reg.ww <= {FULL_W, FULL_W};
      state_reg.wh <= {FULL_H, FULL_H};
      state_reg.target <= `AAWC_RST_TARGET;
      state_reg.lo <= `AAWC_RST_LOWER;
      state_reg.hi <= `AAWC_RST_UPPER;
      state_reg.fn[0].param <= `AAWC_RST_PARAM;
      state_reg.fn[1].param <= `AAWC_RST_PARAM;
      state_reg.fn[0].mode <= AAWC_OFF;
      state_reg.fn[1].mode <= AAWC_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ============================================================
  // Outputs
  // ============================================================
  assign reg_rdata_o = state_reg.rdata;
  assign param0_o = state_reg.fn[0].param;
  assign param1_o = state_reg.fn[1].param;
  assign auto_active_o = {state_reg.fn[1].mode != AAWC_OFF,
                          state_reg.fn[0].mode != AAWC_OFF};

endmodule

// ---- tb/aawc_top_chk.sv ----
`timescale 1ns/1ps
`include "aawc_defines.svh"
// ============================================================
// Port checker
// ============================================================
module aawc_top_chk #(
  parameter logic [15:0] STEP = 16'h0010
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic frame_end_i,
  input wire logic [15:0] param0_o,
  input wire logic [15:0] param1_o,
  input wire logic [1:0] auto_active_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  hold_param0_a: assert property ($changed(param0_o) |->
    $past(frame_end_i) ||
    ($past(reg_wr_i) && $past(reg_addr_i) == `AAWC_OFS_PARAM0))
    else $error("param0 changed without frame end or write");
  hold_param1_a: assert property ($changed(param1_o) |->
    $past(frame_end_i) ||
    ($past(reg_wr_i) && $past(reg_addr_i) == `AAWC_OFS_PARAM1))
    else $error("param1 changed without frame end or write");
  auto_only_a: assert property ($changed(param1_o) &&
    !$past(reg_wr_i) |-> $past(auto_active_o[1]))
    else $error("param1 adjusted while function was off");
  off_stable_a: assert property (!$past(auto_active_o[0]) &&
    !$past(reg_wr_i) |-> $stable(param0_o))
    else $error("param0 moved while function was off");
  enable_by_sw_a: assert property ($rose(auto_active_o[0]) |->
    $past(reg_wr_i) && $past(reg_addr_i) == `AAWC_OFS_MODE0)
    else $error("function 0 enabled without mode write");
  once_stop_a: assert property ($fell(auto_active_o[0]) |->
    $past(frame_end_i) || $past(reg_wr_i))
    else $error("function 0 left on state without cause");
  step_bound_a: assert property ($changed(param0_o) &&
    $past(frame_end_i) && !$past(reg_wr_i) |->
    (param0_o - $past(param0_o) <= STEP) ||
    ($past(param0_o) - param0_o <= STEP))
    else $error("param0 moved by more than one step");
  mode_echo_a: assert property ($past(reg_rd_i) &&
    $past(reg_addr_i) == `AAWC_OFS_MODE0 |->
    (reg_rdata_o != 32'h0) == $past(auto_active_o[0]))
    else $error("mode readback disagrees with active flag");
  rd_idle_a: assert property (!$past(reg_rd_i) |->
    reg_rdata_o == 32'h0)
    else $error("read data not zero outside read answer");

  cover property ($fell(auto_active_o[0]));
  cover property ($changed(param1_o));
  cover property ($past(reg_rd_i) && $past(reg_addr_i) == 8'h30);
endmodule

// ---- tb/aawc_top_bench.sv ----
`timescale 1ns/1ps
`include "aawc_defines.svh"
module aawc_top_bench;
  import aawc_pkg::*;
  localparam int SW = 16;
  localparam int SH = 8;
  localparam logic [15:0] STEP = 16'h0010;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic fs = 1'b0;
  logic fe = 1'b0;
  logic rate_hi = 1'b0;
  logic pv = 1'b0;
  logic [15:0] pc = 16'h0;
  logic [15:0] pr = 16'h0;
  logic [11:0] pd = 12'h0;
  logic [15:0] cx = 16'h0;
  logic [15:0] cw = 16'(SW);
  logic [15:0] cy = 16'h0;
  logic [15:0] ch = 16'(SH);
  logic [31:0] reg_rdata_o;
  logic [15:0] param0_o;
  logic [15:0] param1_o;
  logic [1:0] auto_active_o;
  int n_fail = 0;
  int num_checks = 0;
  int rx = 0;
  int ry = 0;
  int rw = SW;
  int rh = SH;

  aawc_top #(.SENSOR_W(SW), .SENSOR_H(SH)) aawc_top_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .frame_start_i(fs), .frame_end_i(fe),
    .frame_rate_high_i(rate_hi), .pix_valid_i(pv), .pix_col_i(pc),
    .pix_row_i(pr), .pix_data_i(pd), .crop_x_i(cx), .crop_y_i(cy),
    .crop_w_i(cw), .crop_h_i(ch), .param0_o(param0_o),
    .param1_o(param1_o), .auto_active_o(auto_active_o));

  always #2 clock_i = ~clock_i;

  // ============================================================
  // Shared tasks
  // ============================================================
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, reg_rdata_o & m);
  endtask
  // Pixels inside the rectangle rx/ry/rw/rh get gin, all others gout.
  task automatic frame(input logic [7:0] gin, input logic [7:0] gout);
    logic ins;
    @(posedge clock_i);
    fs <= 1'b1;
    @(posedge clock_i);
    fs <= 1'b0;
    for (int r = 0; r < SH; r++) begin
      for (int c = 0; c < SW; c++) begin
        ins = c >= rx && c < rx + rw && r >= ry && r < ry + rh;
        pv <= 1'b1;
        pc <= 16'(c);
        pr <= 16'(r);
        pd <= {(ins ? gin : gout), 4'h0};
        @(posedge clock_i);
      end
    end
    pv <= 1'b0;
    fe <= 1'b1;
    @(posedge clock_i);
    fe <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ============================================================
  // Scenarios
  // ============================================================
  task automatic s_reset();
    rd(`AAWC_OFS_WIN_XOFF, 32'h0);
    rd(`AAWC_OFS_WIN_YOFF, 32'h0);
    rd(`AAWC_OFS_WIN_W, 32'(SW));
    rd(`AAWC_OFS_WIN_H, 32'(SH));
    rd(`AAWC_OFS_TARGET0, 32'h80);
    rd(`AAWC_OFS_UPPER0, 32'hFFFF);
    rd(`AAWC_OFS_MODE0, 32'h0);
    rd(8'h3C, 32'h0);
  endtask
  task automatic s_cont();
    wr(`AAWC_OFS_PARAM0, 32'h5);
    wr(`AAWC_OFS_UPPER0, 32'h30);
    wr(`AAWC_OFS_MODE0, 32'h2);
    frame(8'h10, 8'h10);
    chk("param0", 32'h15, param0_o);
    frame(8'h10, 8'h10);
    chk("param0", 32'h25, param0_o);
    frame(8'h10, 8'h10);
    chk("param0", 32'h30, param0_o);
    rd(`AAWC_OFS_STATUS, 32'h11, 32'h15);
    wr(`AAWC_OFS_MODE0, 32'h0);
    frame(8'h10, 8'h10);
    chk("param0", 32'h30, param0_o);
    wr(`AAWC_OFS_PARAM0, 32'h40);
    #1;
    chk("param0", 32'h40, param0_o);
    wr(`AAWC_OFS_UPPER0, 32'hFFFF);
  endtask
  task automatic s_rate();
    rate_hi <= 1'b1;
    wr(`AAWC_OFS_PARAM1, 32'h100);
    wr(`AAWC_OFS_MODE1, 32'h2);
    frame(8'hF0, 8'hF0);
    chk("param1", 32'hF0, param1_o);
    frame(8'hF0, 8'hF0);
    chk("param1", 32'hF0, param1_o);
    frame(8'hF0, 8'hF0);
    chk("param1", 32'hE0, param1_o);
    wr(`AAWC_OFS_MODE1, 32'h0);
    rate_hi <= 1'b0;
  endtask
  // Only the overlap carries the target grey, so any use of the pixels
  // outside it would pull the average off target and move the parameter.
  task automatic s_window();
    wr(`AAWC_OFS_WIN_SEL, 32'h0);
    wr(`AAWC_OFS_WIN_XOFF, 32'h4);
    wr(`AAWC_OFS_WIN_YOFF, 32'h2);
    wr(`AAWC_OFS_WIN_W, 32'h4);
    wr(`AAWC_OFS_WIN_H, 32'h2);
    {rx, ry, rw, rh} = {32'd4, 32'd2, 32'd4, 32'd2};
    wr(`AAWC_OFS_MODE0, 32'h1);
    frame(8'h80, 8'h00);
    chk("active", 32'h0, 32'(auto_active_o));
    chk("param0", 32'h40, param0_o);
    cx <= 16'h8;
    cw <= 16'h8;
    wr(`AAWC_OFS_MODE0, 32'h2);
    frame(8'h00, 8'h00);
    chk("param0", 32'h40, param0_o);
    rd(`AAWC_OFS_STATUS, 32'h0, 32'h1);
    // Rows alone now keep the window off the crop.
    {cx, cw, cy, ch} <= {16'h0, 16'(SW), 16'h4, 16'h4};
    frame(8'h00, 8'h00);
    rd(`AAWC_OFS_STATUS, 32'h0, 32'h1);
    chk("param0", 32'h40, param0_o);
    {cx, cw, cy, ch} <= {16'h6, 16'hA, 16'h0, 16'(SH)};
    {rx, rw} = {32'd6, 32'd2};
    wr(`AAWC_OFS_MODE0, 32'h1);
    frame(8'h80, 8'h00);
    chk("param0", 32'h40, param0_o);
    rd(`AAWC_OFS_MODE0, 32'h0);
    cx <= 16'h0;
    cw <= 16'(SW);
    wr(`AAWC_OFS_WIN_SEL, 32'h1);
    wr(`AAWC_OFS_WIN_XOFF, 32'h3);
    rd(`AAWC_OFS_WIN_XOFF, 32'h3);
    wr(`AAWC_OFS_WIN_SEL, 32'h0);
    rd(`AAWC_OFS_WIN_XOFF, 32'h4);
  endtask
  task automatic s_once_fail();
    wr(`AAWC_OFS_WIN_XOFF, 32'h0);
    wr(`AAWC_OFS_WIN_W, 32'(SW));
    wr(`AAWC_OFS_WIN_YOFF, 32'h0);
    wr(`AAWC_OFS_WIN_H, 32'(SH));
    {rx, ry, rw, rh} = {32'd0, 32'd0, SW, SH};
    wr(`AAWC_OFS_PARAM0, 32'h0);
    wr(`AAWC_OFS_MODE0, 32'h1);
    repeat (29) frame(8'h00, 8'h00);
    chk("active", 32'h1, 32'(auto_active_o));
    frame(8'h00, 8'h00);
    chk("active", 32'h0, 32'(auto_active_o));
    chk("param0", 32'(STEP) * 30, param0_o);
    wr(`AAWC_OFS_MODE0, 32'h3);
    rd(`AAWC_OFS_MODE0, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    s_reset();
    s_cont();
    s_rate();
    s_window();
    s_once_fail();
    finish_test();
  end
  initial begin
    repeat (40000) @(posedge clock_i);
    n_fail++;
    finish_test();
  end
endmodule

bind aawc_top aawc_top_chk #(.STEP(STEP)) aawc_top_chk_inst (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .frame_end_i(frame_end_i), .param0_o(param0_o), .param1_o(param1_o),
  .auto_active_o(auto_active_o));
